// [rtl/hps_dev.sv]
// Slot control and interrupt logic with its two-wire serial target.
// Assumes the link lines and all slot pins are asynchronous to pclk.
//
// Operation
// - Without bus: power-ok first, then enable rise.
// - Each slot's power state on its pin.
// - Power loss: all off; restart on rise.
// - Aux change, faults, undervoltage, thermal interrupt.
// - Control bits 0 and 2 unmask slots.
// - Masks gate only the pin, not flags.
// - Control bit 4 clears aux-change interrupt.
// - Aux fault clears on disable or power loss.
// - Main fault clears with both enables low.
// - Target address 010000 plus select pin.
// - START is SDA falling with SCL high.
// - Bits move on SCL rising edges.
// - Receiver pulls SDA low on ninth clock.
// - Respond only to matching address; 0 writes.
// - Write: address, pointer, data, then STOP.
// - Read: pointer, repeated START, then data out.
// - Control bits 1 and 3 enable slots.
// - Spare bits 5..7 read back at 11h.
// - Status register layout per slot at 10h.
// - Switch on needs inputs good and enable.
// - Main faults latch until enable cycles.
//
// Register access over APB is this design's own decision.
`timescale 1ns/100ps
module hps_dev (
  // Clock and reset.
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Serial link.
  hps_link_if.dev         lnk,
  // Strap and system inputs.
  input  wire logic       address_select_pin,
  input  wire logic       system_power_ok_in,
  input  wire logic       input_uv_in,
  input  wire logic       thermal_in,
  // Per-slot inputs, slot A in bit 0.
  input  wire logic [1:0] slot_enable_pin,
  input  wire logic [1:0] aux_disable_in,
  input  wire logic [1:0] main_fault_in,
  input  wire logic [1:0] aux_fault_in,
  // Outputs.
  output logic      [1:0] slot_power_ok_out,
  output logic            irq_n
);
  import hps_pkg::*;

  hps_dev_t   r;
  hps_dev_t   n;
  logic       scl;
  logic       sda;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;
  logic       stop_seen;
  logic       pg;
  logic       supply_ok;
  logic [1:0] aux_good;
  logic [1:0] reqv;
  logic [1:0] ctrl_en;
  logic [1:0] ctrl_mask;
  logic [1:0] mf_clr;
  logic [1:0] af_clr;
  logic [7:0] rdata;

  //////////////////////////////////////////////////////////////////////////////
  // Next state: synchronisers, serial target and slot logic.
  always_comb begin
    n    = r;
    n.s1 = {thermal_in, input_uv_in, aux_fault_in, main_fault_in, aux_disable_in,
            slot_enable_pin, system_power_ok_in, address_select_pin, lnk.sda, lnk.scl};
    n.s2 = r.s1;
    n.s3 = r.s2;
    // Only the second and third stages are looked at; the first may be metastable.
    scl        = r.s2[SI_SCL];
    sda        = r.s2[SI_SDA];
    scl_rise   = scl & ~r.s3[SI_SCL];
    scl_fall   = ~scl & r.s3[SI_SCL];
    start_seen = scl & r.s3[SI_SCL] & r.s3[SI_SDA] & ~sda;
    stop_seen  = scl & r.s3[SI_SCL] & ~r.s3[SI_SDA] & sda;
    pg         = r.s2[SI_PG];
    supply_ok  = pg & ~r.s2[SI_UV] & ~r.s2[SI_TH];

    // Per-slot views of the control register and inputs.
    for (int i = 0; i < 2; i++) begin
      ctrl_en[i]   = r.ctrl[CTRL_EN_A + 2*i];
      ctrl_mask[i] = r.ctrl[CTRL_MASK_A + 2*i];
      aux_good[i]  = ~r.s2[SI_AUXD + i] & ~r.afl[i];
      reqv[i]      = r.s2[SI_EN + i] | ctrl_en[i];
      mf_clr[i]    = (~r.s2[SI_EN + i] & ~ctrl_en[i]) | ~pg;
      af_clr[i]    = r.s2[SI_AUXD + i] | ~pg;
    end

    // Readable registers; the write-only control register reads as zero.
    case (r.ptr)
      REG_STAT:    rdata = {1'b0, pg, r.irq[1], aux_good[1], r.on[1],
                            r.irq[0], aux_good[0], r.on[0]};
      REG_CTRL_RB: rdata = r.ctrl;
      default:     rdata = 8'h00;
    endcase

    // Serial target: sample on SCL rise, change SDA after SCL fall.
    case (r.st)
      D_RX: begin
        if (scl_rise) begin
          n.sh  = {r.sh[6:0], sda};
          n.cnt = r.cnt + 4'd1;
        end else if (scl_fall && r.cnt == 4'd8) begin
          n.cnt    = 4'd0;
          n.st     = D_ACK;
          n.sda_oe = 1'b1;
          case (r.kind)
            K_ADDR: begin
              if (r.sh[7:1] == {ADDR_HI, r.s2[SI_ASEL]}) begin
                n.rd = r.sh[0];
              end else begin
                n.st     = D_IDLE;
                n.sda_oe = 1'b0;
              end
            end
            K_PTR: n.ptr = r.sh;
            default: begin
              if (r.ptr == REG_CTRL) begin
                n.ctrl = r.sh;
              end
            end
          endcase
        end
      end
      // Ack is held through the ninth clock and dropped at its falling edge.
      D_ACK: begin
        if (scl_fall) begin
          n.sda_oe = 1'b0;
          if (r.kind == K_ADDR && r.rd) begin
            n.sh     = rdata;
            n.sda_oe = ~rdata[7];
            n.st     = D_TX;
          end else begin
            n.st   = D_RX;
            n.kind = (r.kind == K_ADDR) ? K_PTR : K_DATA;
          end
        end
      end
      D_TX: begin
        if (scl_rise) begin
          n.cnt = r.cnt + 4'd1;
        end else if (scl_fall) begin
          if (r.cnt == 4'd8) begin
            n.sda_oe = 1'b0;
            n.cnt    = 4'd0;
            n.st     = D_MACK;
          end else begin
            n.sh     = {r.sh[6:0], 1'b0};
            n.sda_oe = ~r.sh[6];
          end
        end
      end
      // Master ack repeats the same register; a nack ends the read.
      D_MACK: begin
        if (scl_rise) begin
          n.mack = ~sda;
        end else if (scl_fall) begin
          if (r.mack) begin
            n.sh     = rdata;
            n.sda_oe = ~rdata[7];
            n.st     = D_TX;
          end else begin
            n.st = D_IDLE;
          end
        end
      end
      default: n.st = D_IDLE;
    endcase

    // A START anywhere restarts address reception; STOP frees the bus.
    if (start_seen) begin
      n.st     = D_RX;
      n.kind   = K_ADDR;
      n.cnt    = 4'd0;
      n.sda_oe = 1'b0;
    end else if (stop_seen) begin
      n.st     = D_IDLE;
      n.sda_oe = 1'b0;
    end

    // Slot power, fault latches and interrupt flags; each latch and flag set beats its clear, but a main fault, its latch or a supply not ok beats a slot switch-on.
    for (int i = 0; i < 2; i++) begin
      n.req_q[i] = reqv[i];
      if (!supply_ok || r.mfl[i] || r.s2[SI_MF + i]) begin
        n.on[i] = 1'b0;
      end else if (reqv[i] && !r.req_q[i]) begin
        n.on[i] = 1'b1;
      end else if (!reqv[i]) begin
        n.on[i] = 1'b0;
      end
      n.mfl[i] = r.s2[SI_MF + i] | r.s2[SI_UV] | (r.mfl[i] & ~mf_clr[i]);
      n.afl[i] = r.s2[SI_AF + i] | (r.afl[i] & ~af_clr[i]);
      n.swc[i] = (r.s2[SI_AUXD + i] ^ r.s3[SI_AUXD + i])
                 | (r.swc[i] & ~r.ctrl[CTRL_SWCLR]);
      n.irq[i] = n.swc[i] | n.afl[i] | n.mfl[i] | r.s2[SI_TH];
    end
    n.irq_n = ~|(n.irq & ctrl_mask);
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register; control and outputs start released and slots off.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r       <= '0;
      r.ctrl  <= CTRL_RESET;
      r.irq_n <= IRQ_IDLE;
      // Link lines idle high; starting the stages there avoids a false SCL edge.
      r.s1[SI_SDA:SI_SCL] <= 2'h3;
      r.s2[SI_SDA:SI_SCL] <= 2'h3;
      r.s3[SI_SDA:SI_SCL] <= 2'h3;
    end else begin
      r <= n;
    end
  end

  // Outputs come straight from the state register.
  assign slot_power_ok_out = r.on;
  assign irq_n             = r.irq_n;
  assign lnk.dev_sda_oe    = r.sda_oe;
endmodule

// [inc/hps_pkg.sv]
// Shared constants and types for the hot-plug slot serial control block.
// Assumes both ends run on pclk at 50 MHz and meet through hps_link_if.
package hps_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Device register map and field positions.
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STAT    = 8'h10;
  localparam logic [7:0] REG_CTRL_RB = 8'h11;
  localparam int         CTRL_MASK_A = 0;
  localparam int         CTRL_EN_A   = 1;
  localparam int         CTRL_SWCLR  = 4;
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [5:0] ADDR_HI     = 6'b010000;
  localparam logic       IRQ_IDLE    = 1'b1;

  //////////////////////////////////////////////////////////////////////////////
  // Positions of the synchronised device inputs.
  localparam int NSYNC   = 14;
  localparam int SI_SCL  = 0;
  localparam int SI_SDA  = 1;
  localparam int SI_ASEL = 2;
  localparam int SI_PG   = 3;
  localparam int SI_EN   = 4;
  localparam int SI_AUXD = 6;
  localparam int SI_MF   = 8;
  localparam int SI_AF   = 10;
  localparam int SI_UV   = 12;
  localparam int SI_TH   = 13;

  //////////////////////////////////////////////////////////////////////////////
  // Controller registers on APB and their fields.
  localparam logic [11:0] APB_CMD      = 12'h000;
  localparam logic [11:0] APB_STAT     = 12'h004;
  localparam int          CMD_DATA_LSB = 0;
  localparam int          CMD_PTR_LSB  = 8;
  localparam int          CMD_ADDR_LSB = 16;
  localparam int          CMD_RD_BIT   = 24;

  //////////////////////////////////////////////////////////////////////////////
  // Serial clock timing: one quarter of the SCL period.
  localparam int CLK_NS      = 20;
  localparam int SCL_QTR_NS  = 1000;
  localparam int SCL_QTR_CYC = (SCL_QTR_NS + CLK_NS - 1) / CLK_NS;

  //////////////////////////////////////////////////////////////////////////////
  // State enumerations and state records.
  typedef enum logic [2:0] {D_IDLE, D_RX, D_ACK, D_TX, D_MACK} hps_dst_t;
  typedef enum logic [1:0] {K_ADDR, K_PTR, K_DATA} hps_kind_t;
  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} hps_hst_t;

  typedef struct packed {
    logic [NSYNC-1:0] s1;
    logic [NSYNC-1:0] s2;
    logic [NSYNC-1:0] s3;
    hps_dst_t         st;
    hps_kind_t        kind;
    logic [7:0]       sh;
    logic [3:0]       cnt;
    logic             rd;
    logic             mack;
    logic [7:0]       ptr;
    logic             sda_oe;
    logic [7:0]       ctrl;
    logic [1:0]       on;
    logic [1:0]       mfl;
    logic [1:0]       afl;
    logic [1:0]       swc;
    logic [1:0]       irq;
    logic [1:0]       req_q;
    logic             irq_n;
  } hps_dev_t;

  typedef struct packed {
    logic        sda1;
    logic        sda2;
    hps_hst_t    st;
    logic [2:0]  seg;
    logic [3:0]  bitn;
    logic [1:0]  qc;
    logic [15:0] tmr;
    logic [7:0]  sh;
    logic [6:0]  addr;
    logic [7:0]  ptr;
    logic [7:0]  data;
    logic        rd;
    logic        busy;
    logic        nack;
    logic [7:0]  rdata;
    logic        scl_oe;
    logic        sda_oe;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } hps_host_t;

endpackage

// [inc/hps_link_if.sv]
// Two-wire link between the serial controller and the slot device.
// Both lines are open drain with a pull-up; a line is low while any end enables.
`timescale 1ns/100ps
interface hps_link_if;
  logic host_scl_oe;
  logic host_sda_oe;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // Wired-AND with pull-up: released lines read high.
  assign scl = ~host_scl_oe;
  assign sda = ~(host_sda_oe | dev_sda_oe);

  modport host (output host_scl_oe, output host_sda_oe, input scl, input sda);
  modport dev  (output dev_sda_oe, input scl, input sda);
endinterface

// [rtl/hps_host.sv]
// Serial bus controller: takes orders over APB and runs one register access.
// Assumes an APB master on pclk and a pull-up on both link lines.
`timescale 1ns/100ps
module hps_host #(
  parameter int QTR = hps_pkg::SCL_QTR_CYC
) (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial link.
  hps_link_if.host         lnk
);
  import hps_pkg::*;

  hps_host_t r;
  hps_host_t n;
  logic      tick;

  if (QTR < 8 || QTR > 65535) begin : g_chk
    $error("hps_host: QTR out of range");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state: APB access, quarter-period timer and bit sequencer.
  always_comb begin
    n         = r;
    n.sda1    = lnk.sda;
    n.sda2    = r.sda1;
    n.pready  = 1'b1;
    n.pslverr = 1'b0;
    tick      = (r.tmr == 16'(QTR - 1));
    // Read data is captured in the setup cycle so it stands through the access.
    if (psel && !penable) begin
      n.prdata = (paddr == APB_STAT) ? {16'h0000, r.rdata, 6'h00, r.nack, r.busy} : 32'h0;
    end
    // A command written while busy is dropped; software polls busy first.
    if (psel && penable && pwrite && paddr == APB_CMD && !r.busy) begin
      n.data = pwdata[CMD_DATA_LSB +: 8];
      n.ptr  = pwdata[CMD_PTR_LSB +: 8];
      n.addr = pwdata[CMD_ADDR_LSB +: 7];
      n.rd   = pwdata[CMD_RD_BIT];
      n.busy = 1'b1;
      n.nack = 1'b0;
      n.st   = H_START;
      n.seg  = 3'd0;
      n.qc   = 2'd0;
      n.tmr  = 16'h0000;
    end else if (r.st != H_IDLE) begin
      n.tmr = tick ? 16'h0000 : r.tmr + 16'h0001;
      if (tick) begin
        n.qc = r.qc + 2'd1;
        case (r.st)
          // START: SDA falls while SCL is high; also serves as repeated START.
          H_START: begin
            case (r.qc)
              2'd0: n.scl_oe = 1'b1;
              2'd1: n.sda_oe = 1'b0;
              2'd2: n.scl_oe = 1'b0;
              default: begin
                n.sda_oe = 1'b1;
                n.st     = H_BIT;
                n.bitn   = 4'd0;
                n.sh     = (r.seg == 3'd3) ? {r.addr, 1'b1} : {r.addr, 1'b0};
              end
            endcase
          end
          // One bit per four quarters; SDA changes only while SCL is low.
          H_BIT: begin
            case (r.qc)
              2'd0: n.scl_oe = 1'b1;
              2'd1: n.sda_oe = (r.bitn < 4'd8 && r.seg != 3'd4) ? ~r.sh[7] : 1'b0;
              2'd2: n.scl_oe = 1'b0;
              default: begin
                n.bitn = r.bitn + 4'd1;
                if (r.bitn < 4'd8) begin
                  n.sh = {r.sh[6:0], r.sda2};
                end else begin
                  n.bitn = 4'd0;
                  if (r.seg != 3'd4 && r.sda2) begin
                    n.nack = 1'b1;
                    n.st   = H_STOP;
                  end else begin
                    case (r.seg)
                      3'd0: begin
                        n.seg = 3'd1;
                        n.sh  = r.ptr;
                      end
                      3'd1: begin
                        n.seg = r.rd ? 3'd3 : 3'd2;
                        n.sh  = r.data;
                        n.st  = r.rd ? H_START : H_BIT;
                      end
                      3'd3: begin
                        n.seg = 3'd4;
                        n.sh  = 8'hff;
                      end
                      3'd4: begin
                        n.rdata = r.sh;
                        n.st    = H_STOP;
                      end
                      default: n.st = H_STOP;
                    endcase
                  end
                end
              end
            endcase
          end
          // STOP: SDA rises while SCL is high.
          H_STOP: begin
            case (r.qc)
              2'd0: n.scl_oe = 1'b1;
              2'd1: n.sda_oe = 1'b1;
              2'd2: n.scl_oe = 1'b0;
              default: begin
                n.sda_oe = 1'b0;
                n.st     = H_IDLE;
                n.busy   = 1'b0;
              end
            endcase
          end
          default: n.st = H_IDLE;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // Outputs come straight from the state register.
  assign prdata          = r.prdata;
  assign pready          = r.pready;
  assign pslverr         = r.pslverr;
  assign lnk.host_scl_oe = r.scl_oe;
  assign lnk.host_sda_oe = r.sda_oe;
endmodule

// [dv/hps_props.sv]
// Checker for the two-wire link between the serial controller and the device.
// Assumes one pclk domain and a controller quarter period of ten cycles.
`timescale 1ns/100ps
module hps_props (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Link signals.
  input wire logic host_scl_oe,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic [7:0] hi_cnt;

  ////////////////////////////////////////////////////////////////////////////////
  // Cycles SCL has stood high; past one bit time the bus can only be idle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hi_cnt <= 8'h00;
    else if (!scl) hi_cnt <= 8'h00;
    else if (hi_cnt != 8'hff) hi_cnt <= hi_cnt + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Link timing and ownership.
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_dev_edge_low: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device moved SDA while SCL high");
  a_dev_pull_hold: assert property ($rose(dev_sda_oe) |-> dev_sda_oe [*8])
    else $error("device pull on SDA too short");
  a_dev_release_bound: assert property ($rose(dev_sda_oe) |-> ##[1:450] !dev_sda_oe)
    else $error("device never released SDA");
  a_start_quiet: assert property (scl && $rose(host_sda_oe) |-> !dev_sda_oe [*8])
    else $error("device drove SDA after START");
  a_scl_high_min: assert property ($fell(host_scl_oe) |-> !host_scl_oe [*8])
    else $error("SCL high phase too short");
  a_scl_low_min: assert property ($rose(host_scl_oe) |-> host_scl_oe [*8])
    else $error("SCL low phase too short");
  a_scl_low_bound: assert property (host_scl_oe |-> ##[1:40] !host_scl_oe)
    else $error("SCL held low too long");
  a_idle_released: assert property (hi_cnt == 8'h3c |-> !dev_sda_oe && sda)
    else $error("SDA not released on idle bus");
endmodule

// [dv/hot_plug_slot_serial_control_tb.sv]
// Bench for the slot device and its serial controller joined by the link.
// Assumes pclk at 50 MHz and a shortened quarter period of ten cycles.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module hot_plug_slot_serial_control_tb;
  import hps_pkg::*;
  typedef struct {logic [31:0] e; logic [31:0] m; string nm;} hps_note_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        address_select_pin, system_power_ok_in, input_uv_in, thermal_in, irq_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0]  slot_enable_pin, aux_disable_in, main_fault_in, aux_fault_in, slot_power_ok_out;
  logic [2:0]  sp;
  int          failures, cmp_count, cyc, seed;
  hps_note_t   notes[$];
  hps_note_t   cur;

  hps_link_if lnk ();
  hps_host #(.QTR(10)) hps_host_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lnk(lnk));
  hps_dev hps_dev_inst (.pclk(pclk), .presetn(presetn), .lnk(lnk),
    .address_select_pin(address_select_pin), .system_power_ok_in(system_power_ok_in),
    .input_uv_in(input_uv_in), .thermal_in(thermal_in), .slot_enable_pin(slot_enable_pin),
    .aux_disable_in(aux_disable_in), .main_fault_in(main_fault_in),
    .aux_fault_in(aux_fault_in), .slot_power_ok_out(slot_power_ok_out), .irq_n(irq_n));
  hps_props hps_props_inst (.pclk(pclk), .presetn(presetn), .host_scl_oe(lnk.host_scl_oe),
    .host_sda_oe(lnk.host_sda_oe), .dev_sda_oe(lnk.dev_sda_oe), .scl(lnk.scl), .sda(lnk.sda));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, and a cycle ceiling well above the roughly 35k cycles the tests need.
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 90000) begin
      failures++;
      results();
    end
  end

  // Each completed APB read retires the oldest note; a zero mask marks a poll.
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'b1 && notes.size() > 0) begin
      cur = notes.pop_front();
      if (cur.m != 32'h0) `CHK(cur.nm, cur.e, prdata & cur.m)
      `CHK("pslverr", 1'b0, pslverr)
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB transfers; each starts just after an edge and leaves one idle cycle.
  task automatic apb_xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                          output logic [31:0] q);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask

  // One register access on the link, then a check of the controller status.
  task automatic dev_op(input logic rd, input logic [6:0] ad, input logic [7:0] ptr,
                        input logic [7:0] dat, input logic [31:0] e, input logic [31:0] m,
                        input string nm);
    logic [31:0] q;
    apb_xfer(1'b1, APB_CMD, {7'h00, rd, 1'b0, ad, ptr, dat}, q);
    q = 32'h1;
    for (int i = 0; i < 100 && q[0] !== 1'b0; i++) begin
      notes.push_back('{32'h0, 32'h0, "poll"});
      apb_xfer(1'b0, APB_STAT, 32'h0, q);
      repeat (50) @(posedge pclk);
    end
    notes.push_back('{e, m, nm});
    apb_xfer(1'b0, APB_STAT, 32'h0, q);
  endtask

  task automatic wr(input logic [7:0] ptr, input logic [7:0] dat);
    dev_op(1'b0, {ADDR_HI, address_select_pin}, ptr, dat, 32'h0, 32'h3, "write");
  endtask
  task automatic rd(input logic [7:0] ptr, input logic [7:0] e, input string nm);
    dev_op(1'b1, {ADDR_HI, address_select_pin}, ptr, 8'h00, {16'h0, e, 8'h0}, 32'hff03, nm);
  endtask
  task automatic pause();
    repeat (8) @(posedge pclk);
  endtask

  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    seed = 80; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; address_select_pin = 1'b0; system_power_ok_in = 1'b1;
    input_uv_in = 1'b0; thermal_in = 1'b0; slot_enable_pin = 2'b00; aux_disable_in = 2'b00;
    main_fault_in = 2'b00; aux_fault_in = 2'b00;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK("irq_n", IRQ_IDLE, irq_n)
    `CHK("power_ok", 2'b00, slot_power_ok_out)
    rd(REG_CTRL_RB, CTRL_RESET, "ctrl_rb");
    rd(REG_STAT, 8'h52, "status");
    $display("test reset done");
    // Target address with both select levels; wrong bits must go unanswered.
    for (int a = 0; a < 2; a++) begin
      address_select_pin <= a[0];
      pause();
      dev_op(1'b1, {ADDR_HI, ~a[0]}, REG_STAT, 8'h0, 32'h2, 32'h3, "nack_lsb");
      dev_op(1'b1, {6'b010001, a[0]}, REG_STAT, 8'h0, 32'h2, 32'h3, "nack_hi");
      rd(REG_STAT, 8'h52, "ack_addr");
    end
    $display("test address done");
    sp = 3'($random(seed));
    wr(REG_CTRL, {sp, 5'b00010});
    `CHK("power_ok", 2'b01, slot_power_ok_out)
    rd(REG_CTRL_RB, {sp, 5'b00010}, "spare_rb");
    rd(REG_CTRL, 8'h00, "ctrl_wo");
    rd(REG_STAT, 8'h53, "status_on");
    $display("test enable done");
    aux_disable_in <= 2'b10;
    pause();
    `CHK("irq_n", 1'b1, irq_n)
    rd(REG_STAT, 8'h63, "masked_flag");
    wr(REG_CTRL, {sp, 5'b00110});
    `CHK("irq_n", 1'b0, irq_n)
    wr(REG_CTRL, {sp, 5'b10110});
    `CHK("irq_n", 1'b1, irq_n)
    wr(REG_CTRL, {sp, 5'b00110});
    aux_disable_in <= 2'b00;
    pause();
    `CHK("irq_n", 1'b0, irq_n)
    wr(REG_CTRL, {sp, 5'b10110});
    wr(REG_CTRL, 8'h03);
    `CHK("irq_n", 1'b1, irq_n)
    $display("test aux change done");
    // Main overload, then input undervoltage, each latched until the enable drops.
    for (int k = 0; k < 2; k++) begin
      if (k == 0) main_fault_in <= 2'b01;
      else input_uv_in <= 1'b1;
      pause();
      main_fault_in <= 2'b00; input_uv_in <= 1'b0;
      pause();
      `CHK("power_ok", 2'b00, slot_power_ok_out)
      `CHK("irq_n", 1'b0, irq_n)
      rd(REG_STAT, 8'h56, "main_latch");
      wr(REG_CTRL, 8'h01);
      `CHK("irq_n", 1'b1, irq_n)
      wr(REG_CTRL, 8'h03);
      `CHK("power_ok", 2'b01, slot_power_ok_out)
    end
    $display("test main fault done");
    aux_fault_in <= 2'b01;
    pause();
    aux_fault_in <= 2'b00;
    pause();
    `CHK("irq_n", 1'b0, irq_n)
    rd(REG_STAT, 8'h55, "aux_latch");
    system_power_ok_in <= 1'b0;
    pause();
    `CHK("power_ok", 2'b00, slot_power_ok_out)
    rd(REG_STAT, 8'h12, "power_lost");
    system_power_ok_in <= 1'b1;
    pause();
    `CHK("power_ok", 2'b00, slot_power_ok_out)
    slot_enable_pin <= 2'b10;
    pause();
    `CHK("power_ok", 2'b10, slot_power_ok_out)
    thermal_in <= 1'b1;
    pause();
    `CHK("irq_n", 1'b0, irq_n)
    `CHK("power_ok", 2'b00, slot_power_ok_out)
    rd(8'h20, 8'h00, "unmapped");
    $display("test power loss done");
    results();
  end
endmodule
